/* src/tem_map.vh */
`ifndef TEM_MAP_VH
`define TEM_MAP_VH

////////////////////////////////////////////////////////////////////////////
// register address, byte address of the single control/status word
`define TEM_CTRL_ADDR     32'h4000C03C

// field positions inside external_match_control_status
`define TEM_STATE_LSB     0
`define TEM_STATE_W       4
`define TEM_ACT0_LSB      4
`define TEM_ACT1_LSB      6
`define TEM_ACT2_LSB      8
`define TEM_ACT3_LSB      10
`define TEM_ACT_W         2
`define TEM_USED_W        12

// reset values
`define TEM_CTRL_RESET    32'h00000000
`define TEM_STATE_RESET   4'h0
`define TEM_ACTS_RESET    8'h00

////////////////////////////////////////////////////////////////////////////
// action field encodings
`define TEM_ACT_NONE      2'h0
`define TEM_ACT_CLR       2'h1
`define TEM_ACT_SET       2'h2
`define TEM_ACT_TGL       2'h3

// counter width
`define TEM_CNT_W         16

`endif

/* src/tem_match_chan.v */
`timescale 1ns/1ns
`include "tem_map.vh"

module tem_match_chan #(
  parameter CNT_W = `TEM_CNT_W
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire [CNT_W-1:0] timer_count,
  input  wire [CNT_W-1:0] match_value,
  input  wire             count_update,
  input  wire [1:0]       action,
  input  wire             pwm_mode,
  input  wire             pwm_level,
  input  wire             sw_write,
  input  wire             sw_value,
  output reg              state_ff,
  output reg              hit_ff
);

  // apply one action code to a level
  function apply_action;
    input [1:0] code;
    input       level;
    begin
      case (code)
        `TEM_ACT_NONE: apply_action = level;
        `TEM_ACT_CLR:  apply_action = 1'b0;
        `TEM_ACT_SET:  apply_action = 1'b1;
        `TEM_ACT_TGL:  apply_action = ~level;
        default:       apply_action = level;
      endcase
    end
  endfunction

  wire hit;
  wire base;
  reg  nxt_state;

  // compare only when the count takes a new value
  assign hit  = count_update & (timer_count == match_value);
  // a same-cycle write becomes the level the match acts on
  assign base = sw_write ? sw_value : state_ff;

  // next level: pwm overrides, else match action
  always @* begin
    if (pwm_mode) begin
      nxt_state = pwm_level;
    end else if (hit) begin
      nxt_state = apply_action(action, base);
    end else begin
      nxt_state = base;
    end
  end

  // state and match pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= 1'b0;
      hit_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      hit_ff   <= hit;
    end
  end

endmodule // tem_match_chan

/* src/tem_top.v */
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns
`include "tem_map.vh"

module tem_top #(
  parameter CNT_W = `TEM_CNT_W
) (
  // apb slave
  input  wire             pclk,
  input  wire             presetn,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [31:0]      paddr,
  input  wire [31:0]      pwdata,
  input  wire [3:0]       pstrb,
  output wire             pready,
  output wire             pslverr,
  output reg  [31:0]      prdata,
  // counter core
  input  wire [CNT_W-1:0] timer_count,
  input  wire             count_update,
  input  wire [CNT_W-1:0] match_value_0,
  input  wire [CNT_W-1:0] match_value_1,
  input  wire [CNT_W-1:0] match_value_2,
  input  wire [CNT_W-1:0] match_value_3,
  // pwm logic
  input  wire [3:0]       pwm_mode,
  input  wire [3:0]       pwm_level,
  // pin configuration, one select per pinned channel
  input  wire [1:0]       pin_configuration,
  // match outputs
  output wire [1:0]       match_output_pins,
  output wire [1:0]       match_pin_oe_n,
  output wire [3:0]       match_state,
  output wire [3:0]       match_event
);

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  wire        addr_hit;
  wire        setup_rd;
  wire        acc_wr;
  wire        lane0_wr;
  wire        lane1_wr;

  // the single word decodes on the full byte address
  assign addr_hit = (paddr == `TEM_CTRL_ADDR);
  assign setup_rd = psel & ~penable & ~pwrite & addr_hit;
  assign acc_wr   = psel & penable & pwrite & addr_hit;
  // byte lanes: lane 0 holds state bits and fields 0,1
  assign lane0_wr = acc_wr & pstrb[0];
  // lane 1 holds fields 2,3
  assign lane1_wr = acc_wr & pstrb[1];

  // zero wait states, unmapped access answers with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;

  ////////////////////////////////////////////////////////////////////////
  // action fields

  reg  [7:0] act_ff;
  reg  [7:0] nxt_act;
  wire [1:0] act_0;
  wire [1:0] act_1;
  wire [1:0] act_2;
  wire [1:0] act_3;

  // field writes honour byte strobes
  always @* begin
    nxt_act = act_ff;
    if (lane0_wr) begin
      nxt_act[3:0] = pwdata[`TEM_ACT0_LSB+3:`TEM_ACT0_LSB];
    end
    if (lane1_wr) begin
      nxt_act[7:4] = pwdata[`TEM_ACT2_LSB+3:`TEM_ACT2_LSB];
    end
  end

  // field storage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_ff <= `TEM_ACTS_RESET;
    end else begin
      act_ff <= nxt_act;
    end
  end

  // per-channel field slices
  assign act_0 = act_ff[1:0];
  assign act_1 = act_ff[3:2];
  assign act_2 = act_ff[5:4];
  assign act_3 = act_ff[7:6];

  ////////////////////////////////////////////////////////////////////////
  // match channels

  wire [3:0] state_q;
  wire [3:0] hit_q;

  // channel 0, also drives pin 0
  tem_match_chan #(
    .CNT_W        (CNT_W)
  ) u_chan0 (
    .pclk         (pclk),
    .presetn      (presetn),
    .timer_count  (timer_count),
    .match_value  (match_value_0),
    .count_update (count_update),
    .action       (act_0),
    .pwm_mode     (pwm_mode[0]),
    .pwm_level    (pwm_level[0]),
    .sw_write     (lane0_wr),
    .sw_value     (pwdata[`TEM_STATE_LSB]),
    .state_ff     (state_q[0]),
    .hit_ff       (hit_q[0])
  );

  // channel 1, also drives pin 1
  tem_match_chan #(
    .CNT_W        (CNT_W)
  ) u_chan1 (
    .pclk         (pclk),
    .presetn      (presetn),
    .timer_count  (timer_count),
    .match_value  (match_value_1),
    .count_update (count_update),
    .action       (act_1),
    .pwm_mode     (pwm_mode[1]),
    .pwm_level    (pwm_level[1]),
    .sw_write     (lane0_wr),
    .sw_value     (pwdata[`TEM_STATE_LSB+1]),
    .state_ff     (state_q[1]),
    .hit_ff       (hit_q[1])
  );

  // channel 2, internal only
  tem_match_chan #(
    .CNT_W        (CNT_W)
  ) u_chan2 (
    .pclk         (pclk),
    .presetn      (presetn),
    .timer_count  (timer_count),
    .match_value  (match_value_2),
    .count_update (count_update),
    .action       (act_2),
    .pwm_mode     (pwm_mode[2]),
    .pwm_level    (pwm_level[2]),
    .sw_write     (lane0_wr),
    .sw_value     (pwdata[`TEM_STATE_LSB+2]),
    .state_ff     (state_q[2]),
    .hit_ff       (hit_q[2])
  );

  // channel 3, internal only
  tem_match_chan #(
    .CNT_W        (CNT_W)
  ) u_chan3 (
    .pclk         (pclk),
    .presetn      (presetn),
    .timer_count  (timer_count),
    .match_value  (match_value_3),
    .count_update (count_update),
    .action       (act_3),
    .pwm_mode     (pwm_mode[3]),
    .pwm_level    (pwm_level[3]),
    .sw_write     (lane0_wr),
    .sw_value     (pwdata[`TEM_STATE_LSB+3]),
    .state_ff     (state_q[3]),
    .hit_ff       (hit_q[3])
  );

  ////////////////////////////////////////////////////////////////////////
  // outputs

  // state bits are visible whether or not pinned out
  assign match_state = state_q;
  assign match_event = hit_q;

  // pin level straight from the state flops, 0 low and 1 high
  assign match_output_pins = state_q[1:0];
  // enable is low while the match function owns the pin
  assign match_pin_oe_n = ~pin_configuration;

  ////////////////////////////////////////////////////////////////////////
  // read data

  wire [31:0] rd_word;

  // reserved bits above the used fields read zero
  assign rd_word = {{(32-`TEM_USED_W){1'b0}}, act_ff, state_q};

  // captured in the setup cycle, held until the next read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `TEM_CTRL_RESET;
    end else if (setup_rd) begin
      prdata <= rd_word;
    end
  end

endmodule // tem_top

/* test/tem_top_sva.sv */
`timescale 1ns/1ns
module tem_top_sva #(
  parameter CNT_W = 16
) (
  input wire             pclk,
  input wire             presetn,
  input wire             psel,
  input wire             penable,
  input wire             pwrite,
  input wire [31:0]      paddr,
  input wire [31:0]      pwdata,
  input wire [3:0]       pstrb,
  input wire [CNT_W-1:0] timer_count,
  input wire             count_update,
  input wire [CNT_W-1:0] match_value_0,
  input wire [CNT_W-1:0] match_value_1,
  input wire [CNT_W-1:0] match_value_2,
  input wire [CNT_W-1:0] match_value_3,
  input wire [3:0]       pwm_mode,
  input wire [3:0]       pwm_level,
  input wire [1:0]       pin_configuration,
  input wire [1:0]       match_output_pins,
  input wire [1:0]       match_pin_oe_n,
  input wire [3:0]       match_state
);
  // decoded write and per channel hits
  wire       wr = psel & penable & pwrite & (paddr == 32'h4000C03C);
  wire [3:0] eq = {timer_count == match_value_3,
                   timer_count == match_value_2,
                   timer_count == match_value_1,
                   timer_count == match_value_0};
  wire [3:0] hit = eq & ~pwm_mode & {4{count_update & ~wr}};
  reg  [7:0] act_ff;

  // shadow of the action fields
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_ff <= 8'h00;
    end else if (wr) begin
      if (pstrb[0]) act_ff[3:0] <= pwdata[7:4];
      if (pstrb[1]) act_ff[7:4] <= pwdata[11:8];
    end
  end

  function automatic logic nx(input logic [1:0] a, input logic s);
    nx = a == 2'h0 ? s : a == 2'h1 ? 1'b0 : a == 2'h2 ? 1'b1 : ~s;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PIN: assert property (match_output_pins == match_state[1:0])
    else $error("pin level differs from state");
  AST_OE: assert property (match_pin_oe_n == ~pin_configuration)
    else $error("pin enable wrong");
  AST_CH0: assert property (hit[0] |=> match_state[0] ==
    nx($past(act_ff[1:0]), $past(match_state[0]))) else $error("ch0");
  AST_CH1: assert property (hit[1] |=> match_state[1] ==
    nx($past(act_ff[3:2]), $past(match_state[1]))) else $error("ch1");
  AST_CH2: assert property (hit[2] |=> match_state[2] ==
    nx($past(act_ff[5:4]), $past(match_state[2]))) else $error("ch2");
  AST_CH3: assert property (hit[3] |=> match_state[3] ==
    nx($past(act_ff[7:6]), $past(match_state[3]))) else $error("ch3");
  AST_WR: assert property (wr && pstrb[0] && !count_update &&
    pwm_mode == 4'h0 |=> match_state == $past(pwdata[3:0]))
    else $error("written state lost");
  AST_PWM: assert property ($past(pwm_mode[0]) |->
    match_state[0] == $past(pwm_level[0])) else $error("pwm level");

  cover property (hit[0] && act_ff[1:0] == 2'h3);
  cover property (wr && pstrb == 4'h2);
  cover property (pwm_mode[0] ##1 pwm_mode[0]);
endmodule // tem_top_sva

bind tem_top tem_top_sva #(.CNT_W(CNT_W)) u_sva (.*);

/* test/timer_external_match_outputs_bench.sv */
`timescale 1ns/1ns
module timer_external_match_outputs_bench;
  localparam [31:0] ADR = 32'h4000C03C;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        count_update = 0, pready, pslverr, er;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd, d;
  logic [15:0] timer_count = 0, match_value_0 = 0, match_value_1 = 0;
  logic [15:0] match_value_2 = 0, match_value_3 = 0;
  logic [3:0]  pstrb = 4'hF, pwm_mode = 4'h0, pwm_level = 4'h0, eq, xs;
  logic [3:0]  match_state, match_event;
  logic [7:0]  xa;
  logic [1:0]  pin_configuration = 0, match_output_pins, match_pin_oe_n;
  integer      fail_count = 0, n_compared = 0, seed = 32'h57d73753, i, j;

  tem_top DUT (.*);

  // clock
  always #5 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////
  task stop_test;
    if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask

  function logic nx(input logic [1:0] a, input logic s);
    nx = a == 2'h0 ? s : a == 2'h1 ? 1'b0 : a == 2'h2 ? 1'b1 : ~s;
  endfunction

  // one apb transfer, waits for pready
  task apb(input logic w, input logic [31:0] a, dw, input logic [3:0] s);
    integer k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dw;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      stop_test;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ADR, 32'h0, 4'hF);
    chk(rd, 32'h0);
    apb(1, ADR + 4, 32'hFFF, 4'hF);
    chk(er, 32'h1);
    apb(0, ADR, 32'h0, 4'hF);
    chk(rd, 32'h0);
    for (i = 0; i < 40; i++) begin
      d = $random(seed);
      apb(1, ADR, d, 4'hF);
      xs = d[3:0];
      xa = d[11:4];
      pin_configuration <= d[13:12];
      @(posedge pclk);
      chk(match_state, xs);
      chk(match_pin_oe_n ^ d[13:12], 32'h3);
      chk(match_output_pins, xs[1:0]);
      eq = $random(seed);
      timer_count <= d[31:16];
      match_value_0 <= eq[0] ? d[31:16] : ~d[31:16];
      match_value_1 <= eq[1] ? d[31:16] : ~d[31:16];
      match_value_2 <= eq[2] ? d[31:16] : ~d[31:16];
      match_value_3 <= eq[3] ? d[31:16] : ~d[31:16];
      count_update <= 1'b1;
      @(posedge pclk);
      count_update <= 1'b0;
      for (j = 0; j < 4; j++) if (eq[j]) xs[j] = nx(xa[2*j+:2], xs[j]);
      #1;
      chk(match_state, xs);
      chk(match_event, eq);
      apb(0, ADR, 32'h0, 4'hF);
      chk(rd, {xa, xs});
      chk(match_event, 32'h0);
    end
    // upper lane only
    apb(1, ADR, 32'hFFF, 4'h2);
    apb(0, ADR, 32'h0, 4'hF);
    chk(rd, {4'hF, xa[3:0], xs});
    // pwm override
    pwm_level <= 4'hA;
    pwm_mode <= 4'hF;
    repeat (2) @(posedge pclk);
    #1;
    chk(match_state, 32'hA);
    @(posedge pclk);
    pwm_mode <= 4'h0;
    stop_test;
  end
endmodule // timer_external_match_outputs_bench
